// ===== verilog/pattern_match_trigger.sv
// seventeen-input pattern-match trigger with serial control chain and apb status port
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pattern_match_trigger #(
  parameter int N = pmt_pkg::N_INPUTS,
  parameter int LEN = pmt_pkg::SHIFT_LEN,
  parameter int CW = pmt_pkg::COUNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_shift_clock,
  input wire logic serial_match_data,
  output logic shift_return_out,
  input wire logic qualifier_clock,
  input wire logic [N-1:0] match_data_in,
  output logic match_output_connector
);
  pmt_pkg::cfg_type cfg;
  logic cmp_match_n;
  logic qual_rise_r;
  logic qual_fall_r;
  logic sync_match_n;
  logic sel_match_n;

  pmt_pkg::apb_state_type apb_state_r;
  pmt_pkg::apb_state_type apb_state_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic out_en_r;
  logic out_en_nxt;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;

  logic match_meta_r;
  logic match_sync_r;
  logic match_prev_r;
  logic rtrn_meta_r;
  logic rtrn_sync_r;
  logic match_fall;
  logic setup_cycle;
  logic wr_count;
  logic access_cycle;

  control_shift_chain #(
    .LEN(LEN)
  ) u_chain (
    .serial_shift_clock(serial_shift_clock),
    .presetn(presetn),
    .serial_match_data(serial_match_data),
    .shift_return_out(shift_return_out),
    .cfg(cfg)
  );

  // low when every gated input sits at its programmed level
  function automatic logic compare_n(input logic [N-1:0] din, input logic [N-1:0] pol, input logic [N-1:0] dc);
    logic [N-1:0] miss;
    miss = (din ^ pol) & ~dc;
    compare_n = |miss;
  endfunction

  // purely combinational so asynchronous mode has no clock in the trigger path
  assign cmp_match_n = compare_n(match_data_in, cfg.pol, cfg.dc);

  // both edges are captured and the chain bit picks one; avoids a gated or inverted clock
  always_ff @(posedge qualifier_clock or negedge presetn)
  begin
    if (!presetn)
    begin
      qual_rise_r <= 1'b1;
    end
    else
    begin
      qual_rise_r <= cmp_match_n;
    end
  end

  always_ff @(negedge qualifier_clock or negedge presetn)
  begin
    if (!presetn)
    begin
      qual_fall_r <= 1'b1;
    end
    else
    begin
      qual_fall_r <= cmp_match_n;
    end
  end

  assign sync_match_n = cfg.edge_fall ? qual_fall_r : qual_rise_r;
  assign sel_match_n = cfg.mode_sync ? sync_match_n : cmp_match_n;
  // software enable holds the trigger inactive until the chain has been loaded
  assign match_output_connector = out_en_r ? sel_match_n : 1'b1;

  // status paths into the bus clock; the connector path itself stays off the bus clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_meta_r <= 1'b1;
      match_sync_r <= 1'b1;
      match_prev_r <= 1'b1;
      rtrn_meta_r <= 1'b0;
      rtrn_sync_r <= 1'b0;
    end
    else
    begin
      match_meta_r <= match_output_connector;
      match_sync_r <= match_meta_r;
      match_prev_r <= match_sync_r;
      rtrn_meta_r <= shift_return_out;
      rtrn_sync_r <= rtrn_meta_r;
    end
  end

  // pulses shorter than one bus clock may be missed by the counter
  assign match_fall = match_prev_r & ~match_sync_r;
  assign setup_cycle = psel & ~penable;
  // writes land in the access phase, so a transfer dropped after setup changes nothing
  assign access_cycle = psel & penable & (apb_state_r == pmt_pkg::APB_ACCESS);
  assign wr_count = access_cycle & pwrite & (paddr == pmt_pkg::COUNT_OFF);

  always_comb
  begin
    apb_state_nxt = apb_state_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    out_en_nxt = out_en_r;
    count_nxt = count_r;
    if (wr_count)
    begin
      count_nxt = '0;
    end
    // an event in the clearing cycle still counts
    if (match_fall)
    begin
      count_nxt = wr_count ? CW'(pmt_pkg::COUNT_ONE) : count_r + CW'(pmt_pkg::COUNT_ONE);
    end
    case (apb_state_r)
      pmt_pkg::APB_IDLE:
      begin
        if (setup_cycle)
        begin
          apb_state_nxt = pmt_pkg::APB_ACCESS;
          prdata_nxt = pmt_pkg::RDATA_ZERO;
          pslverr_nxt = 1'b0;
          case (paddr)
            pmt_pkg::CTRL_OFF:
            begin
              if (!pwrite)
              begin
                prdata_nxt[pmt_pkg::CTRL_EN_BIT] = out_en_r;
              end
            end
            pmt_pkg::STATUS_OFF:
            begin
              prdata_nxt[pmt_pkg::STAT_MATCH_BIT] = match_sync_r;
              prdata_nxt[pmt_pkg::STAT_RTRN_BIT] = rtrn_sync_r;
            end
            pmt_pkg::COUNT_OFF:
            begin
              if (!pwrite)
              begin
                prdata_nxt[CW-1:0] = count_r;
              end
            end
            default:
            begin
              pslverr_nxt = 1'b1;
            end
          endcase
        end
      end
      pmt_pkg::APB_ACCESS:
      begin
        apb_state_nxt = pmt_pkg::APB_IDLE;
        if (access_cycle && pwrite && (paddr == pmt_pkg::CTRL_OFF))
        begin
          out_en_nxt = pwdata[pmt_pkg::CTRL_EN_BIT];
        end
      end
      default:
      begin
        apb_state_nxt = pmt_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_state_r <= pmt_pkg::APB_IDLE;
      prdata_r <= pmt_pkg::RDATA_ZERO;
      pslverr_r <= 1'b0;
      out_en_r <= pmt_pkg::CTRL_EN_RESET;
      count_r <= CW'(pmt_pkg::COUNT_ZERO);
    end
    else
    begin
      apb_state_r <= apb_state_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      out_en_r <= out_en_nxt;
      count_r <= count_nxt;
    end
  end

  assign pready = (apb_state_r == pmt_pkg::APB_ACCESS);
  assign prdata = pready ? prdata_r : pmt_pkg::RDATA_ZERO;
  assign pslverr = pready & pslverr_r;

  property p_all_match_low;
    @(posedge pclk) disable iff (!presetn)
      (((match_data_in ~^ cfg.pol) | cfg.dc) == {N{1'b1}}) |-> !cmp_match_n;
  endproperty
  a_all_match_low: assert property (p_all_match_low) else $error("full match did not drive comparator low");

  property p_mismatch_high;
    @(posedge pclk) disable iff (!presetn)
      (((match_data_in ^ cfg.pol) & ~cfg.dc) != '0) |-> cmp_match_n;
  endproperty
  a_mismatch_high: assert property (p_mismatch_high) else $error("enabled mismatch let comparator go low");

  property p_all_ignored;
    @(posedge pclk) disable iff (!presetn)
      (cfg.dc == {N{1'b1}}) |-> !cmp_match_n;
  endproperty
  a_all_ignored: assert property (p_all_ignored) else $error("ignored inputs blocked the match");

  property p_polarity_only;
    @(posedge pclk) disable iff (!presetn)
      (cfg.dc == '0) |-> (cmp_match_n == (match_data_in != cfg.pol));
  endproperty
  a_polarity_only: assert property (p_polarity_only) else $error("polarity compare wrong with none ignored");

  property p_async_mode;
    @(posedge pclk) disable iff (!presetn)
      (out_en_r && !cfg.mode_sync) |-> (match_output_connector == cmp_match_n);
  endproperty
  a_async_mode: assert property (p_async_mode) else $error("asynchronous mode not forwarding comparator");

  property p_sync_mode;
    @(posedge pclk) disable iff (!presetn)
      (out_en_r && cfg.mode_sync) |-> (match_output_connector == (cfg.edge_fall ? qual_fall_r : qual_rise_r));
  endproperty
  a_sync_mode: assert property (p_sync_mode) else $error("synchronous mode not forwarding synchronizer");

  property p_rise_sample;
    @(posedge qualifier_clock) disable iff (!presetn)
      1'b1 |=> (qual_rise_r == $past(cmp_match_n));
  endproperty
  a_rise_sample: assert property (p_rise_sample) else $error("rising-edge sample lost");

  property p_fall_sample;
    @(negedge qualifier_clock) disable iff (!presetn)
      1'b1 |=> (qual_fall_r == $past(cmp_match_n));
  endproperty
  a_fall_sample: assert property (p_fall_sample) else $error("falling-edge sample lost");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && apb_state_r == pmt_pkg::APB_IDLE) |=> (pready && psel && penable) ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb access not answered in one wait-free cycle");

  property p_count_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr_count && !match_fall) |=> (count_r == '0);
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("match counter not cleared by write");

  property p_disabled_idle;
    @(posedge pclk) disable iff (!presetn)
      !out_en_r |-> match_output_connector;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("output active while disabled");

  property p_write_in_access;
    @(posedge pclk) disable iff (!presetn)
      (access_cycle && pwrite && paddr == pmt_pkg::CTRL_OFF)
        |=> (out_en_r == $past(pwdata[pmt_pkg::CTRL_EN_BIT]));
  endproperty
  a_write_in_access: assert property (p_write_in_access) else $error("control write not taken in access phase");

  property p_setup_no_write;
    @(posedge pclk) disable iff (!presetn)
      (setup_cycle && apb_state_r == pmt_pkg::APB_IDLE) |=> (out_en_r == $past(out_en_r));
  endproperty
  a_setup_no_write: assert property (p_setup_no_write) else $error("control changed in setup phase");

  property p_err_with_ready;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error response outside access phase");

  property p_rdata_idle;
    @(posedge pclk) disable iff (!presetn)
      !pready |-> (prdata == pmt_pkg::RDATA_ZERO);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero between transfers");

  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
      (match_fall && !wr_count) |=> (count_r == $past(count_r) + CW'(pmt_pkg::COUNT_ONE));
  endproperty
  a_count_step: assert property (p_count_step) else $error("match event not counted");

  property p_count_set_wins;
    @(posedge pclk) disable iff (!presetn)
      (match_fall && wr_count) |=> (count_r == CW'(pmt_pkg::COUNT_ONE));
  endproperty
  a_count_set_wins: assert property (p_count_set_wins) else $error("clear beat a match event in the same cycle");

  c_async_hit: cover property (@(posedge pclk) disable iff (!presetn)
    out_en_r && !cfg.mode_sync && !match_output_connector);
  c_sync_fall: cover property (@(posedge pclk) disable iff (!presetn)
    out_en_r && cfg.mode_sync && cfg.edge_fall && !match_output_connector);
  c_counted: cover property (@(posedge pclk) disable iff (!presetn) match_fall);
  c_set_wins: cover property (@(posedge pclk) disable iff (!presetn) match_fall && wr_count);
  c_slverr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule
`default_nettype wire

// ===== pkg/pmt_pkg.sv
// constants, layouts and types shared by the pattern-match trigger files
package pmt_pkg;
  localparam int N_INPUTS = 17;
  localparam int SHIFT_LEN = 40;
  // control chain layout, bit 0 holds the most recently shifted bit
  localparam int DC_LSB = 0;
  localparam int POL_LSB = 17;
  localparam int EDGE_BIT = 34;
  localparam int MODE_BIT = 35;
  // all inputs ignored, polarity low, rising edge, asynchronous mode
  localparam logic [39:0] CHAIN_RESET = 40'h00_0001_FFFF;
  // apb register map
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] COUNT_OFF = 12'h008;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_MATCH_BIT = 0;
  localparam int STAT_RTRN_BIT = 1;
  localparam logic CTRL_EN_RESET = 1'b0;
  localparam int COUNT_W = 16;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  typedef struct packed {
    logic mode_sync;
    logic edge_fall;
    logic [16:0] pol;
    logic [16:0] dc;
  } cfg_type;
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ACCESS = 2'b10
  } apb_state_type;
endpackage

// ===== verilog/control_shift_chain.sv
// serial control chain on the shift clock, with return tap and decoded configuration
`timescale 1ns/1ps
`default_nettype none
module control_shift_chain #(
  parameter int LEN = pmt_pkg::SHIFT_LEN
) (
  input wire logic serial_shift_clock,
  input wire logic presetn,
  input wire logic serial_match_data,
  output logic shift_return_out,
  output pmt_pkg::cfg_type cfg
);
  logic rst_meta_r;
  logic rst_sync_r;
  logic [LEN-1:0] chain_r;
  logic [LEN-1:0] chain_nxt;
  logic [5:0] fill_r;
  logic [5:0] fill_nxt;

  // reset release retimed to this clock so the chain leaves reset cleanly
  always_ff @(posedge serial_shift_clock or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_comb
  begin
    chain_nxt = {chain_r[LEN-2:0], serial_match_data};
    fill_nxt = (fill_r == 6'(LEN)) ? fill_r : fill_r + 6'h01;
  end

  always_ff @(posedge serial_shift_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      chain_r <= pmt_pkg::CHAIN_RESET[LEN-1:0];
      fill_r <= 6'h00;
    end
    else
    begin
      chain_r <= chain_nxt;
      fill_r <= fill_nxt;
    end
  end

  assign shift_return_out = chain_r[LEN-1];
  assign cfg.dc = chain_r[pmt_pkg::DC_LSB +: pmt_pkg::N_INPUTS];
  assign cfg.pol = chain_r[pmt_pkg::POL_LSB +: pmt_pkg::N_INPUTS];
  assign cfg.edge_fall = chain_r[pmt_pkg::EDGE_BIT];
  assign cfg.mode_sync = chain_r[pmt_pkg::MODE_BIT];

  property p_return_delay;
    @(posedge serial_shift_clock) disable iff (!rst_sync_r)
      (fill_r == 6'(LEN)) |-> (shift_return_out == $past(serial_match_data, LEN));
  endproperty
  a_return_delay: assert property (p_return_delay) else $error("return bit not forty clocks late");

  property p_one_per_clock;
    @(posedge serial_shift_clock) disable iff (!rst_sync_r)
      (fill_r >= 6'h02) |-> (chain_r[1] == $past(serial_match_data, 2));
  endproperty
  a_one_per_clock: assert property (p_one_per_clock) else $error("chain did not move one bit per clock");
endmodule
`default_nettype wire

// ===== verif/shift_host.sv
// host-side model that loads the control chain and collects the returned bits
`timescale 1ns/1ps
`default_nettype none
module shift_host (
  output logic serial_shift_clock,
  output logic serial_match_data,
  input wire logic shift_return_out
);
  initial
  begin
    serial_shift_clock = 1'b0;
    serial_match_data = 1'b0;
  end
  // clock runs only inside pulse calls, 64 ns period
  task automatic pulse(input logic d);
    serial_match_data = d;
    #32 serial_shift_clock = 1'b1;
    #32 serial_shift_clock = 1'b0;
  endtask
  // return is sampled just before each rising edge, so it rebuilds the previous word
  task automatic load(input logic [39:0] w, output logic [39:0] ret);
    for (int i = 39; i >= 0; i--)
    begin
      ret = {ret[38:0], shift_return_out};
      pulse(w[i]);
    end
    // released line must not keep showing the last bit
    serial_match_data = ~w[0];
  endtask
endmodule
`default_nettype wire

// ===== verif/pattern_match_trigger_tb.sv
// self-checking bench for the pattern-match trigger
`timescale 1ns/1ps
`default_nettype none
module pattern_match_trigger_tb;
  localparam logic [16:0] PAT = 17'h1A5C3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, qualifier_clock;
  logic serial_shift_clock, serial_match_data, shift_return_out, match_output_connector;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [16:0] match_data_in;
  logic [39:0] ret, last;
  logic [16:0] vec [6];
  logic prev, expv;
  int fail_count, cmp_count, falls;
  pattern_match_trigger dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_shift_clock(serial_shift_clock), .serial_match_data(serial_match_data),
    .shift_return_out(shift_return_out), .qualifier_clock(qualifier_clock),
    .match_data_in(match_data_in), .match_output_connector(match_output_connector));
  shift_host host (.serial_shift_clock(serial_shift_clock), .serial_match_data(serial_match_data),
    .shift_return_out(shift_return_out));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      $display("ERROR at %0t: apb transfer not answered", $time);
      fail_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [39:0] word(input logic m, input logic e, input logic [16:0] p,
    input logic [16:0] d);
    pmt_pkg::cfg_type c;
    c = '{mode_sync: m, edge_fall: e, pol: p, dc: d};
    return {4'h0, c};
  endfunction
  // active low: low only when every enabled input equals its polarity
  function automatic logic exp_out(input logic [16:0] p, input logic [16:0] d, input logic [16:0] v);
    return ~&((v ~^ p) | d);
  endfunction
  task automatic ld(input logic [39:0] w);
    host.load(w, ret);
    chk(ret, last);
    last = w;
  endtask
  task automatic drive(input logic [16:0] v);
    @(posedge pclk);
    match_data_in <= v;
    repeat (4) @(posedge pclk);
  endtask
  task automatic qtog();
    @(posedge pclk);
    qualifier_clock <= ~qualifier_clock;
    repeat (3) @(posedge pclk);
  endtask
  initial
  begin
    #200000;
    $display("ERROR at %0t: watchdog expired", $time);
    fail_count++;
    conclude();
  end
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, qualifier_clock} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    match_data_in = 17'h00000;
    last = pmt_pkg::CHAIN_RESET;
    vec = '{PAT, PAT ^ 17'h00001, PAT, PAT ^ 17'h10000, ~PAT, PAT};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pmt_pkg::CTRL_OFF, 32'h0000_0000);
    chk(rd, 40'h0);
    apb(1'b0, pmt_pkg::COUNT_OFF, 32'h0000_0000);
    chk(rd, 40'h0);
    apb(1'b1, 12'h00C, 32'h0000_0001);
    chk(err, 40'h1);
    chk(match_output_connector, 40'h1);
    // chain reset releases only after two shift clocks
    host.pulse(1'b0);
    host.pulse(1'b0);
    ld(word(1'b0, 1'b0, PAT, 17'h1FFFF));
    apb(1'b1, pmt_pkg::CTRL_OFF, 32'h0000_0001);
    apb(1'b0, pmt_pkg::CTRL_OFF, 32'h0000_0000);
    chk(rd, 40'h1);
    drive(~PAT);
    chk(match_output_connector, 40'h0);
    $display("test reset and enable done");
    ld(word(1'b0, 1'b0, PAT, 17'h00000));
    drive(~PAT);
    apb(1'b1, pmt_pkg::COUNT_OFF, 32'h0000_0000);
    prev = 1'b1;
    falls = 0;
    for (int i = 0; i < 6; i++)
    begin
      drive(vec[i]);
      expv = exp_out(PAT, 17'h00000, vec[i]);
      chk(match_output_connector, expv);
      if (prev && !expv)
        falls++;
      prev = expv;
    end
    apb(1'b0, pmt_pkg::COUNT_OFF, 32'h0000_0000);
    chk(rd, falls);
    $display("test async compare done");
    // spare top bit set so the returned status bit reads high
    ld(word(1'b0, 1'b0, PAT, 17'h00001) | 40'h80_0000_0000);
    drive(PAT ^ 17'h00001);
    chk(match_output_connector, 40'h0);
    apb(1'b0, pmt_pkg::STATUS_OFF, 32'h0000_0000);
    chk(rd[pmt_pkg::STAT_MATCH_BIT], 40'h0);
    chk(rd[pmt_pkg::STAT_RTRN_BIT], 40'h1);
    drive(PAT ^ 17'h00002);
    chk(match_output_connector, 40'h1);
    $display("test dont care done");
    for (int e = 0; e < 2; e++)
    begin
      @(posedge pclk);
      qualifier_clock <= e[0];
      ld(word(1'b1, e[0], PAT, 17'h00000));
      drive(PAT);
      qtog();
      chk(match_output_connector, 40'h0);
      drive(~PAT);
      chk(match_output_connector, 40'h0);
      qtog();
      chk(match_output_connector, 40'h0);
      qtog();
      chk(match_output_connector, 40'h1);
    end
    $display("test sync edges done");
    conclude();
  end
endmodule
`default_nettype wire
